// File: src/ldw_defines.vh
`ifndef LDW_DEFINES_VH
`define LDW_DEFINES_VH

// Control word field positions
`define LDW_CW_ADDR_LSB     0
`define LDW_CW_ADDR_MSB     2
`define LDW_CW_BANK         3
`define LDW_CW_POWER        4
`define LDW_CW_BYPASS       5
`define LDW_CW_SCHEME       6
`define LDW_CW_SEQ          7

// Display RAM word fields
`define LDW_RW_NIB_MSB      3
`define LDW_RW_DP           7

// Reset values
`define LDW_CW_RESET        8'h00
`define LDW_CFG_RESET       32'h00000000

// Sequential update last digit index, first digit index
`define LDW_SEQ_LAST        3'h7
`define LDW_DIGIT_FIRST     3'h0

// APB map, byte addresses
`define LDW_ADDR_CFG        8'h00
`define LDW_ADDR_STATUS     8'h04
`define LDW_ADDR_IGNORED    8'h08
`define LDW_ADDR_RAM_BASE   8'h40
`define LDW_RAM_SEL_MSB     7
`define LDW_RAM_SEL_LSB     6
`define LDW_RAM_SEL_VAL     2'h1
`define LDW_RAM_IDX_MSB     5
`define LDW_RAM_IDX_LSB     2

// Configuration register fields
`define LDW_CFG_DIRECT      0

// Status register fields
`define LDW_ST_CW_MSB       7
`define LDW_ST_SEQ_ACT      8
`define LDW_ST_CNT_LSB      9
`define LDW_ST_CNT_MSB      11
`define LDW_ST_SINGLE       12
`define LDW_ST_BLANK        13
`define LDW_ST_POWER        14
`define LDW_ST_HEX          15
`define LDW_ST_BYPASS       16
`define LDW_ST_BANK_A       17
`define LDW_ST_DIRECT       18

`endif

// File: src/ldw_ram.v
`timescale 1ns/1ps
// Display RAM: one write port, one read port with registered data
module ldw_ram #(
	parameter AW = 4,
	parameter DW = 8
) (
	input  wire          pclk,
	input  wire          presetn,
	input  wire          wr_en,
	input  wire [AW-1:0] wr_addr,
	input  wire [DW-1:0] wr_data,
	input  wire [AW-1:0] rd_addr,
	output reg  [DW-1:0] rd_data_ff
);
	reg [DW-1:0] mem_ff [0:(1<<AW)-1];
	integer      i;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (i = 0; i < (1<<AW); i = i + 1)
				mem_ff[i] <= {DW{1'b0}};
			rd_data_ff <= {DW{1'b0}};
		end else begin
			if (wr_en)
				mem_ff[wr_addr] <= wr_data;
			rd_data_ff <= mem_ff[rd_addr];
		end
	end
endmodule // ldw_ram

// File: src/ldw_port.v
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
// Operation
// RL1: Data is captured into control register or RAM at write strobe rise.
// RL2: Select high loads the control register, low loads display RAM.
// RL3: RAM writes map data lines 0..4 to display bits 1..5, LSB first.
// RL4: Control line 4 high runs normally; low stops oscillator and display.
// RL5: Sequential bit low: lines 0..2 give the single-digit target address.
// RL6: Control line 3 picks bank A high, B low, in decoded formats only.
// RL7: Direct variant reads three address inputs as digit index, bit 0 LSB.
// RL8: Direct variant decimal point input is active low; low lights it.
// RL9: Direct variant stores every strobe straight into the addressed digit.
// RL10: Three-level input: high hex, float Code B, low shuts down.
// RL11: Control line 6 picks hex high, Code B low; RAM bit 7 otherwise.
// RL12: Control line 5 high bypasses decoding; low shows decoded digits.
// RL13: Control line 7 requests sequential update; RAM bit 8 is decimal point.
// RL14: Sequential update blanks, takes eight writes digit 1..8, then ignores.
// RL15: Strobe is synchronised, its rise detected, inputs sampled once.
// RL16: Last control word holds until the next control write.
`include "ldw_defines.vh"
module ldw_port #(
	parameter DIGITS_AW = 3,
	parameter DATA_W    = 8
) (
	input  wire              pclk,
	input  wire              presetn,
	// Write port pins
	input  wire              write_strobe,
	input  wire              mode_select,
	input  wire [DATA_W-1:0] data_lines,
	input  wire [2:0]        digit_index,
	input  wire              decimal_point_data_n,
	input  wire              func_sense_high,
	input  wire              func_sense_low,
	// APB slave
	input  wire              psel,
	input  wire              penable,
	input  wire              pwrite,
	input  wire [7:0]        paddr,
	input  wire [31:0]       pwdata,
	output wire              pready,
	output reg  [31:0]       prdata_ff,
	output wire              pslverr,
	// Display state
	output reg               power_on_ff,
	output reg               hex_decode_ff,
	output reg               decode_bypass_ff,
	output reg               bank_a_ff,
	output reg               display_blank_ff,
	output reg               write_event_ff
);
	localparam RAM_AW = DIGITS_AW + 1;

	// Pin synchronisers
	reg              strobe_s1_ff;
	reg              strobe_s2_ff;
	reg              strobe_d_ff;
	reg              mode_s1_ff;
	reg              mode_s2_ff;
	reg [DATA_W-1:0] data_s1_ff;
	reg [DATA_W-1:0] data_s2_ff;
	reg [2:0]        idx_s1_ff;
	reg [2:0]        idx_s2_ff;
	reg              dpn_s1_ff;
	reg              dpn_s2_ff;
	reg              fhi_s1_ff;
	reg              fhi_s2_ff;
	reg              flo_s1_ff;
	reg              flo_s2_ff;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strobe_s1_ff <= 1'b0;
			strobe_s2_ff <= 1'b0;
			strobe_d_ff  <= 1'b0;
			mode_s1_ff   <= 1'b0;
			mode_s2_ff   <= 1'b0;
			data_s1_ff   <= {DATA_W{1'b0}};
			data_s2_ff   <= {DATA_W{1'b0}};
			idx_s1_ff    <= 3'h0;
			idx_s2_ff    <= 3'h0;
			dpn_s1_ff    <= 1'b1;
			dpn_s2_ff    <= 1'b1;
			fhi_s1_ff    <= 1'b0;
			fhi_s2_ff    <= 1'b0;
			flo_s1_ff    <= 1'b0;
			flo_s2_ff    <= 1'b0;
		end else begin
			strobe_s1_ff <= write_strobe; // RL15
			strobe_s2_ff <= strobe_s1_ff;
			strobe_d_ff  <= strobe_s2_ff;
			mode_s1_ff   <= mode_select;
			mode_s2_ff   <= mode_s1_ff;
			data_s1_ff   <= data_lines;
			data_s2_ff   <= data_s1_ff;
			idx_s1_ff    <= digit_index;
			idx_s2_ff    <= idx_s1_ff;
			dpn_s1_ff    <= decimal_point_data_n;
			dpn_s2_ff    <= dpn_s1_ff;
			fhi_s1_ff    <= func_sense_high;
			fhi_s2_ff    <= fhi_s1_ff;
			flo_s1_ff    <= func_sense_low;
			flo_s2_ff    <= flo_s1_ff;
		end
	end

	// One pulse per strobe rise; inputs are sampled in this cycle only
	wire strobe_rise = strobe_s2_ff & ~strobe_d_ff; // RL1 RL15

	// Configuration and tracking state
	reg [31:0]       cfg_ff;
	reg [DATA_W-1:0] cw_ff;
	reg              seq_active_ff;
	reg [2:0]        seq_cnt_ff;
	reg              single_pend_ff;
	reg [15:0]       ignored_ff;
	reg [31:0]       nxt_prdata;
	reg              ack_ff;

	wire direct_mode = cfg_ff[`LDW_CFG_DIRECT];

	// Three-level function input: neither sense level means floating
	wire func_hex   = fhi_s2_ff & ~flo_s2_ff;
	wire func_off   = flo_s2_ff & ~fhi_s2_ff;

	wire cw_write   = strobe_rise & ~direct_mode & mode_s2_ff; // RL2
	wire ram_strobe = strobe_rise & ~direct_mode & ~mode_s2_ff; // RL2
	wire seq_write  = ram_strobe & seq_active_ff;
	wire one_write  = ram_strobe & ~seq_active_ff & single_pend_ff;
	wire ign_write  = ram_strobe & ~seq_active_ff & ~single_pend_ff;

	// Bank is only meaningful in decoded formats
	wire cw_bank_a  = cw_ff[`LDW_CW_BANK] & ~cw_ff[`LDW_CW_BYPASS]; // RL6

	// Control register with sequential and single-digit tracking
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cw_ff          <= `LDW_CW_RESET;
			seq_active_ff  <= 1'b0;
			seq_cnt_ff     <= `LDW_DIGIT_FIRST;
			single_pend_ff <= 1'b0;
		end else if (cw_write) begin
			cw_ff          <= data_s2_ff; // RL16
			seq_active_ff  <= data_s2_ff[`LDW_CW_SEQ]; // RL13
			seq_cnt_ff     <= `LDW_DIGIT_FIRST; // RL14
			single_pend_ff <= ~data_s2_ff[`LDW_CW_SEQ]; // RL5
		end else if (seq_write) begin
			seq_cnt_ff <= seq_cnt_ff + 3'h1; // RL14
			if (seq_cnt_ff == `LDW_SEQ_LAST)
				seq_active_ff <= 1'b0; // RL14
		end else if (one_write) begin
			single_pend_ff <= 1'b0;
		end
	end

	// RAM write address and data
	reg               ram_we;
	reg [RAM_AW-1:0]  ram_waddr;
	reg [DATA_W-1:0]  ram_wdata;
	reg [2:0]         wr_digit;
	reg               wr_bank_b;

	always @* begin
		wr_digit  = cw_ff[`LDW_CW_ADDR_MSB:`LDW_CW_ADDR_LSB]; // RL5
		wr_bank_b = ~cw_bank_a;
		ram_wdata = data_s2_ff; // RL3 RL11 RL13
		ram_we    = 1'b0;
		if (direct_mode) begin
			// Direct variant: nibble plus decimal point, no control phase
			wr_digit  = idx_s2_ff; // RL7
			wr_bank_b = 1'b0;
			ram_wdata = {DATA_W{1'b0}};
			ram_wdata[`LDW_RW_NIB_MSB:0] =
				data_s2_ff[`LDW_RW_NIB_MSB:0];
			ram_wdata[`LDW_RW_DP] = ~dpn_s2_ff; // RL8
			ram_we    = strobe_rise; // RL9
		end else if (seq_write) begin
			wr_digit = seq_cnt_ff; // RL14
			ram_we   = 1'b1;
		end else if (one_write) begin
			ram_we = 1'b1; // RL5
		end
		ram_waddr = {wr_bank_b, wr_digit};
	end

	// Display state outputs
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power_on_ff      <= 1'b0;
			hex_decode_ff    <= 1'b0;
			decode_bypass_ff <= 1'b0;
			bank_a_ff        <= 1'b0;
			display_blank_ff <= 1'b0;
			write_event_ff   <= 1'b0;
		end else if (direct_mode) begin
			power_on_ff      <= ~func_off; // RL10
			hex_decode_ff    <= func_hex; // RL10
			decode_bypass_ff <= 1'b0;
			bank_a_ff        <= 1'b0;
			display_blank_ff <= 1'b0;
			write_event_ff   <= ram_we;
		end else begin
			power_on_ff      <= cw_ff[`LDW_CW_POWER]; // RL4
			hex_decode_ff    <= cw_ff[`LDW_CW_SCHEME]; // RL11
			decode_bypass_ff <= cw_ff[`LDW_CW_BYPASS]; // RL12
			bank_a_ff        <= cw_bank_a; // RL6
			display_blank_ff <= seq_active_ff; // RL14
			write_event_ff   <= ram_we | cw_write;
		end
	end

	// Count of RAM writes refused outside an update window
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ignored_ff <= 16'h0000;
		else if (ign_write && ignored_ff != 16'hFFFF)
			ignored_ff <= ignored_ff + 16'h0001; // RL14
	end

	// APB decode
	wire              apb_access = psel & penable;
	wire              ram_sel    =
		(paddr[`LDW_RAM_SEL_MSB:`LDW_RAM_SEL_LSB] == `LDW_RAM_SEL_VAL);
	wire [RAM_AW-1:0] ram_raddr  =
		paddr[`LDW_RAM_IDX_MSB:`LDW_RAM_IDX_LSB];
	wire [DATA_W-1:0] ram_rdata;
	wire              rd_mapped  = ram_sel |
		(paddr == `LDW_ADDR_CFG) | (paddr == `LDW_ADDR_STATUS) |
		(paddr == `LDW_ADDR_IGNORED);
	wire              wr_mapped  = (paddr == `LDW_ADDR_CFG);

	// Writes finish at once; reads take one wait cycle
	assign pready  = pwrite | ack_ff;
	assign pslverr = apb_access & pready &
		(pwrite ? ~wr_mapped : ~rd_mapped);

	always @* begin
		nxt_prdata = 32'h00000000;
		if (ram_sel) begin
			nxt_prdata[DATA_W-1:0] = ram_rdata;
		end else if (paddr == `LDW_ADDR_CFG) begin
			nxt_prdata = cfg_ff;
		end else if (paddr == `LDW_ADDR_STATUS) begin
			nxt_prdata[`LDW_ST_CW_MSB:0]  = cw_ff;
			nxt_prdata[`LDW_ST_SEQ_ACT]   = seq_active_ff;
			nxt_prdata[`LDW_ST_CNT_MSB:`LDW_ST_CNT_LSB] = seq_cnt_ff;
			nxt_prdata[`LDW_ST_SINGLE]    = single_pend_ff;
			nxt_prdata[`LDW_ST_BLANK]     = display_blank_ff;
			nxt_prdata[`LDW_ST_POWER]     = power_on_ff;
			nxt_prdata[`LDW_ST_HEX]       = hex_decode_ff;
			nxt_prdata[`LDW_ST_BYPASS]    = decode_bypass_ff;
			nxt_prdata[`LDW_ST_BANK_A]    = bank_a_ff;
			nxt_prdata[`LDW_ST_DIRECT]    = direct_mode;
		end else if (paddr == `LDW_ADDR_IGNORED) begin
			nxt_prdata[15:0] = ignored_ff;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_ff    <= `LDW_CFG_RESET;
			ack_ff    <= 1'b0;
			prdata_ff <= 32'h00000000;
		end else begin
			ack_ff <= apb_access & ~pwrite & ~ack_ff;
			if (apb_access && !pwrite && !ack_ff)
				prdata_ff <= nxt_prdata;
			if (apb_access && pwrite && wr_mapped)
				cfg_ff <= {31'h00000000, pwdata[`LDW_CFG_DIRECT]};
		end
	end

	ldw_ram #(
		.AW (RAM_AW),
		.DW (DATA_W)
	) u_ram (
		.pclk       (pclk),
		.presetn    (presetn),
		.wr_en      (ram_we),
		.wr_addr    (ram_waddr),
		.wr_data    (ram_wdata),
		.rd_addr    (ram_raddr),
		.rd_data_ff (ram_rdata)
	);
endmodule // ldw_port

// File: dv/ldw_port_sva.sv
`timescale 1ns/1ps
module ldw_port_sva (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        write_strobe,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        decode_bypass_ff,
	input wire logic        bank_a_ff,
	input wire logic        display_blank_ff,
	input wire logic        write_event_ff
);
	logic       strb_q_ff;
	logic [3:0] since_ff;
	logic [3:0] quiet_ff;
	wire        rise = write_strobe & ~strb_q_ff;
	// Cycles since the last pin strobe rise, and since the last strobe rise or APB select
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strb_q_ff <= 1'b0;
			since_ff  <= 4'hF;
			quiet_ff  <= 4'h0;
		end else begin
			strb_q_ff <= write_strobe;
			since_ff  <= rise ? 4'h0 : since_ff + {3'h0, since_ff != 4'hF};
			quiet_ff  <= (rise | psel) ? 4'h0 :
				quiet_ff + {3'h0, quiet_ff != 4'hF};
		end
	end
	property p_wr_ready;
		@(posedge pclk) disable iff (!presetn)
		psel && penable && pwrite |-> pready;
	endproperty
	a_wr_ready: assert property (p_wr_ready) else $error("write not ready");
	property p_rd_wait;
		@(posedge pclk) disable iff (!presetn)
		psel && !penable && !pwrite ##1 psel && penable |-> !pready ##1 pready;
	endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
	property p_err_ready;
		@(posedge pclk) disable iff (!presetn)
		pslverr |-> pready && psel && penable;
	endproperty
	a_err_ready: assert property (p_err_ready) else $error("stray error");
	property p_wr_refuse;
		@(posedge pclk) disable iff (!presetn)
		psel && penable && pwrite && paddr != 8'h00 |-> pslverr;
	endproperty
	a_wr_refuse: assert property (p_wr_refuse) else $error("no refusal");
	property p_evt_pulse;
		@(posedge pclk) disable iff (!presetn)
		write_event_ff |=> !write_event_ff;
	endproperty
	a_evt_pulse: assert property (p_evt_pulse) else $error("event long");
	property p_evt_win;
		@(posedge pclk) disable iff (!presetn)
		write_event_ff |-> since_ff >= 4'h2 && since_ff <= 4'h7;
	endproperty
	a_evt_win: assert property (p_evt_win) else $error("event timing");
	property p_blank_cause;
		@(posedge pclk) disable iff (!presetn)
		$rose(display_blank_ff) |-> since_ff <= 4'h7;
	endproperty
	a_blank_cause: assert property (p_blank_cause) else $error("blank");
	property p_bank_nodec;
		@(posedge pclk) disable iff (!presetn)
		decode_bypass_ff |-> !bank_a_ff;
	endproperty
	a_bank_nodec: assert property (p_bank_nodec) else $error("bank");
	property p_cw_hold;
		@(posedge pclk) disable iff (!presetn)
		quiet_ff > 4'hA |-> $stable(decode_bypass_ff);
	endproperty
	a_cw_hold: assert property (p_cw_hold) else $error("cw moved");
endmodule // ldw_port_sva
bind ldw_port ldw_port_sva i_ldw_port_sva (.pclk(pclk), .presetn(presetn),
	.write_strobe(write_strobe), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
	.decode_bypass_ff(decode_bypass_ff), .bank_a_ff(bank_a_ff),
	.display_blank_ff(display_blank_ff), .write_event_ff(write_event_ff));

// File: dv/ldw_host_model.sv
`timescale 1ns/1ps
module ldw_host_model (
	input wire logic  pclk,
	output logic       write_strobe,
	output logic       mode_select,
	output logic [7:0] data_lines,
	output logic [2:0] digit_index,
	output logic       decimal_point_data_n,
	output logic       func_sense_high,
	output logic       func_sense_low
);
	initial begin
		write_strobe = 1'b0;
		mode_select = 1'b0;
		data_lines = 8'h00;
		digit_index = 3'h0;
		decimal_point_data_n = 1'b1;
		func_sense_high = 1'b0;
		func_sense_low = 1'b0;
	end
	// One strobe cycle; bus shows inverted data once released
	task automatic pin_write(input logic m, input logic [7:0] d,
		input logic [2:0] idx, input logic dpn);
		@(posedge pclk);
		mode_select <= m;
		data_lines <= d;
		digit_index <= idx;
		decimal_point_data_n <= dpn;
		repeat (4) @(posedge pclk);
		write_strobe <= 1'b1;
		repeat (4) @(posedge pclk);
		write_strobe <= 1'b0;
		mode_select <= ~m;
		data_lines <= ~d;
		digit_index <= ~idx;
		decimal_point_data_n <= ~dpn;
		repeat (4) @(posedge pclk);
	endtask
	task automatic set_func(input logic hi, input logic lo);
		@(posedge pclk);
		func_sense_high <= hi;
		func_sense_low <= lo;
		repeat (8) @(posedge pclk);
	endtask
endmodule // ldw_host_model

// File: dv/ldw_port_tb.sv
`timescale 1ns/1ps
module ldw_port_tb;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic        ws, ms, dpn, fh, fl, pw_on, hex, byp, bka, blank, wev;
	logic [7:0]  paddr, dl;
	logic [2:0]  di;
	logic [31:0] pwdata, prdata, rd;
	int          fail_count, n_tests, cyc, i, n_evt;
	ldw_host_model i_ldw_host_model (.pclk(pclk), .write_strobe(ws),
		.mode_select(ms), .data_lines(dl), .digit_index(di),
		.decimal_point_data_n(dpn), .func_sense_high(fh), .func_sense_low(fl));
	ldw_port i_ldw_port (.pclk(pclk), .presetn(presetn), .write_strobe(ws),
		.mode_select(ms), .data_lines(dl), .digit_index(di),
		.decimal_point_data_n(dpn), .func_sense_high(fh),
		.func_sense_low(fl), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata_ff(prdata),
		.pslverr(pslverr), .power_on_ff(pw_on), .hex_decode_ff(hex),
		.decode_bypass_ff(byp), .bank_a_ff(bka), .display_blank_ff(blank),
		.write_event_ff(wev));
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	task report_and_stop;
		if (fail_count == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		// Accepted writes, control and RAM alike
		if (wev === 1'b1)
			n_evt <= n_evt + 1;
		if (cyc == 20000) begin
			fail_count++;
			$display("mismatch %0t timeout", $time);
			report_and_stop();
		end
	end
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %0t got %h exp %h", $time, g, e);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// Only pready or the bench timeout ends this wait
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task pw(input logic m, input logic [7:0] d);
		i_ldw_host_model.pin_write(m, d, 3'h0, 1'b1);
	endtask
	task t_reset;
		chk({pw_on, hex, byp, bka, blank}, 5'h00);
		apb(1'b0, 8'h04, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 8'h0C, 32'h0);
		chk(err, 1'b1);
		chk(rd, 32'h0);
	endtask
	task t_single;
		pw(1'b1, 8'h5D);
		chk({pw_on, hex, byp, bka, blank}, 5'b11010);
		pw(1'b0, 8'h8A);
		apb(1'b0, 8'h54, 32'h0);
		chk(rd, 32'h8A);
		pw(1'b0, 8'h33);
		apb(1'b0, 8'h54, 32'h0);
		chk(rd, 32'h8A);
	endtask
	task t_seq;
		pw(1'b1, 8'h90);
		chk({blank, bka, hex}, 3'b100);
		for (i = 0; i < 8; i++)
			pw(1'b0, 8'(i * 17));
		chk(blank, 1'b0);
		pw(1'b0, 8'hFF);
		chk(n_evt, 32'h0000000B);
		for (i = 0; i < 8; i++) begin
			apb(1'b0, 8'(8'h60 + 4 * i), 32'h0);
			chk(rd, 32'(i * 17));
		end
		apb(1'b0, 8'h08, 32'h0);
		chk(rd, 32'h2);
		apb(1'b0, 8'h04, 32'h0);
		chk(rd[7:0], 8'h90);
	endtask
	task t_bypass;
		pw(1'b1, 8'h38);
		chk({byp, bka, pw_on}, 3'b101);
	endtask
	task t_direct;
		apb(1'b1, 8'h00, 32'h1);
		i_ldw_host_model.set_func(1'b1, 1'b0);
		chk({hex, pw_on}, 2'b11);
		i_ldw_host_model.pin_write(1'b0, 8'h05, 3'h3, 1'b0);
		apb(1'b0, 8'h4C, 32'h0);
		chk(rd, 32'h85);
		i_ldw_host_model.set_func(1'b0, 1'b0);
		chk({hex, pw_on}, 2'b01);
		i_ldw_host_model.set_func(1'b0, 1'b1);
		chk(pw_on, 1'b0);
		apb(1'b1, 8'h04, 32'h5);
		chk(err, 1'b1);
	endtask
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		fail_count = 0;
		n_tests = 0;
		cyc = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_single();
		t_seq();
		t_bypass();
		t_direct();
		report_and_stop();
	end
endmodule // ldw_port_tb
